// ### mfs_pkg.sv
// Constants and carrier types for the fault cause status bytes.
// Assumes a single processor clock and a synchronous system reset.
package mfs_pkg;

    // -------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------
    localparam logic [31:0] MFS_FAULT_WORD_ADDR = 32'hE000_ED28;
    localparam logic [1:0]  MFS_MEMPROT_LANE    = 2'h0;
    localparam logic [1:0]  MFS_BUS_LANE        = 2'h1;

    // -------------------------------------------------------------
    // Access sizes
    // -------------------------------------------------------------
    localparam logic [1:0] MFS_SIZE_BYTE = 2'h0;
    localparam logic [1:0] MFS_SIZE_HALF = 2'h1;
    localparam logic [1:0] MFS_SIZE_WORD = 2'h2;

    // -------------------------------------------------------------
    // Field positions, shared by both bytes except bit 2 (imprecise), which only the bus byte has
    // -------------------------------------------------------------
    localparam int MFS_BIT_ADDR_VALID = 7;
    localparam int MFS_BIT_LAZY_FP    = 5;
    localparam int MFS_BIT_STACKING   = 4;
    localparam int MFS_BIT_UNSTACKING = 3;
    localparam int MFS_BIT_IMPRECISE  = 2;
    localparam int MFS_BIT_DATA       = 1;
    localparam int MFS_BIT_FETCH      = 0;

    // Writable (clearable) bits; reserved bits read zero
    localparam logic [7:0] MFS_MEMPROT_MASK = 8'hBB;
    localparam logic [7:0] MFS_BUS_MASK     = 8'hBF;
    localparam logic [7:0] MFS_CAUSE_RESET  = 8'h00;
    localparam logic [31:0] MFS_ADDR_RESET  = 32'h0000_0000;
    localparam logic       MFS_FPU_PRESENT  = 1'b1;

    // -------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------
    typedef struct packed {
        logic fetch_access_violation;
        logic data_access_violation;
        logic memprot_stacking_fault;
        logic memprot_unstacking_fault;
        logic memprot_lazy_fp_fault;
        logic precise_data_bus_error;
        logic imprecise_data_bus_error;
        logic bus_stacking_fault;
        logic bus_unstacking_fault;
        logic bus_lazy_fp_fault;
        logic prefetch_bus_error;
        logic prefetch_issue;
        logic prefetch_flush;
    } mfs_fault_ev_type;

    typedef struct packed {
        logic adjust_sp;
        logic keep_return_frame;
        logic stacked_pc_faulting;
    } mfs_frame_ctl_type;

endpackage

// ### mfs_fault_status.sv
// Memory-protection and bus fault cause bytes with shared fault address storage.
// Assumes fault events arrive as one-cycle pulses from core logic on mclk_in.
// Notes on behaviour
// RULE1 - Memprot valid bit 7 reads one only while fault address storage holds its address.
// RULE2 - Escalated-fault software clears the memprot valid bit by writing one.
// RULE3 - Lazy floating-point memprot fault sets memprot bit 5, FPU variants only.
// RULE4 - Memprot stacking fault sets bit 4, still adjusts SP, loads no address.
// RULE5 - Memprot unstacking fault sets bit 3, chains, no SP adjust, no save, no address.
// RULE6 - Data access violation sets bit 1, faulting PC stacked, address loaded.
// RULE7 - Fetch from execute-never region sets bit 0 regardless of protection unit.
// RULE8 - Bus valid bit 7 set after a bus fault with known address.
// RULE9 - A later memprot address load clears the bus valid bit.
// RULE10 - Escalated-fault software clears the bus valid bit before returning.
// RULE11 - Lazy floating-point bus error sets bus bit 5, FPU variants only.
// RULE12 - Bus stacking fault sets bit 4, still adjusts SP, writes no address.
// RULE13 - Bus unstacking fault sets bit 3, chains, keeps frame, writes no address.
// RULE14 - Precise data bus error sets bit 1, faulting PC stacked, address written.
// RULE15 - Imprecise error sets bit 2, no address, pends while higher priority runs.
// RULE16 - Instruction bus error sets bit 0 only when prefetched instruction issues.
// RULE17 - Memprot byte at word base, bus byte at next byte address.
// RULE18 - Flags stay set until software clears them; reserved bits read zero.
// RULE19 - System reset clears all flags and both valid bits.
`timescale 1ns/10ps
`default_nettype none

module mfs_fault_status
    import mfs_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    // Fault events from the core
    input  wire mfs_fault_ev_type  fault_ev_in,
    input  wire logic [31:0]       data_fault_addr_in,
    input  wire logic [31:0]       bus_fault_addr_in,
    // Priorities, lower value is higher priority
    input  wire logic [7:0]        cur_prio_in,
    input  wire logic [7:0]        bus_prio_in,
    input  wire logic              bus_fault_taken_in,
    // System control space access
    input  wire logic [31:0]       sc_addr_in,
    input  wire logic [1:0]        sc_size_in,
    input  wire logic              sc_rd_in,
    input  wire logic              sc_wr_in,
    input  wire logic [31:0]       sc_wdata_in,
    output logic [31:0]            sc_rdata_out,
    // Fault results
    output logic [7:0]             memprot_fault_cause_out,
    output logic [7:0]             bus_fault_cause_out,
    output logic [31:0]            fault_addr_out,
    output mfs_frame_ctl_type      frame_ctl_out,
    output logic                   bus_fault_req_out
);

    // -------------------------------------------------------------
    // Lane decode
    // -------------------------------------------------------------
    function automatic logic lane_hit(input logic [31:0] addr,
                                      input logic [1:0]  size,
                                      input logic [1:0]  lane);
        logic hit;
        hit = 1'b0;
        if (addr[31:2] != MFS_FAULT_WORD_ADDR[31:2]) begin
            hit = 1'b0;
        end else if (size == MFS_SIZE_WORD) begin
            hit = 1'b1;
        end else if (size == MFS_SIZE_HALF) begin
            hit = (addr[1] == lane[1]);
        end else if (size == MFS_SIZE_BYTE) begin
            hit = (addr[1:0] == lane);
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    logic [7:0]  memprot_fault_cause;
    logic [7:0]  bus_fault_cause;
    logic [31:0] fault_addr;
    logic        prefetch_err;
    logic        imprecise_pend;
    logic [31:0] rdata;
    mfs_frame_ctl_type frame_ctl;

    logic [7:0]  next_memprot_fault_cause;
    logic [7:0]  next_bus_fault_cause;
    logic [31:0] next_fault_addr;
    logic        next_prefetch_err;
    logic        next_imprecise_pend;
    logic [31:0] next_rdata;
    mfs_frame_ctl_type next_frame_ctl;

    logic [7:0]  mp_set;
    logic [7:0]  bus_set;
    logic [7:0]  mp_clr;
    logic [7:0]  bus_clr;
    logic        mp_hit;
    logic        bus_hit;
    logic        bus_blocked;

    assign mp_hit      = lane_hit(sc_addr_in, sc_size_in, MFS_MEMPROT_LANE);
    assign bus_hit     = lane_hit(sc_addr_in, sc_size_in, MFS_BUS_LANE);
    assign bus_blocked = (cur_prio_in <= bus_prio_in);

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        mp_set  = 8'h00;
        bus_set = 8'h00;
        mp_clr  = 8'h00;
        bus_clr = 8'h00;
        next_fault_addr     = fault_addr;
        next_prefetch_err   = prefetch_err;
        next_imprecise_pend = imprecise_pend;
        next_rdata          = rdata;
        next_frame_ctl      = '0;

        // RULE7 fetch violation, no enable gating
        mp_set[MFS_BIT_FETCH]      = fault_ev_in.fetch_access_violation;
        // RULE6 data violation flag
        mp_set[MFS_BIT_DATA]       = fault_ev_in.data_access_violation;
        // RULE4 memprot stacking flag
        mp_set[MFS_BIT_STACKING]   = fault_ev_in.memprot_stacking_fault;
        // RULE5 memprot unstacking flag
        mp_set[MFS_BIT_UNSTACKING] = fault_ev_in.memprot_unstacking_fault;
        // RULE3 memprot lazy flag
        mp_set[MFS_BIT_LAZY_FP]    = fault_ev_in.memprot_lazy_fp_fault & MFS_FPU_PRESENT;
        // RULE1 valid follows address load
        mp_set[MFS_BIT_ADDR_VALID] = fault_ev_in.data_access_violation;

        // RULE14 precise bus flag
        bus_set[MFS_BIT_DATA]       = fault_ev_in.precise_data_bus_error;
        // RULE15 imprecise flag
        bus_set[MFS_BIT_IMPRECISE]  = fault_ev_in.imprecise_data_bus_error;
        // RULE12 bus stacking flag
        bus_set[MFS_BIT_STACKING]   = fault_ev_in.bus_stacking_fault;
        // RULE13 bus unstacking flag
        bus_set[MFS_BIT_UNSTACKING] = fault_ev_in.bus_unstacking_fault;
        // RULE11 bus lazy flag
        bus_set[MFS_BIT_LAZY_FP]    = fault_ev_in.bus_lazy_fp_fault & MFS_FPU_PRESENT;
        // RULE8 bus valid on known address
        bus_set[MFS_BIT_ADDR_VALID] = fault_ev_in.precise_data_bus_error
                                      & ~fault_ev_in.data_access_violation;

        // RULE16 prefetch error waits for issue
        if (fault_ev_in.prefetch_issue && (prefetch_err || fault_ev_in.prefetch_bus_error)) begin
            bus_set[MFS_BIT_FETCH] = 1'b1;
            next_prefetch_err      = 1'b0;
        end else if (fault_ev_in.prefetch_flush) begin
            next_prefetch_err = 1'b0;
        end else if (fault_ev_in.prefetch_bus_error) begin
            next_prefetch_err = 1'b1;
        end

        // RULE2 software clears by writing one
        // RULE10 software clears by writing one
        if (sc_wr_in && mp_hit) begin
            mp_clr = sc_wdata_in[7:0] & MFS_MEMPROT_MASK;
        end
        if (sc_wr_in && bus_hit) begin
            bus_clr = sc_wdata_in[15:8] & MFS_BUS_MASK;
        end

        // RULE9 shared storage overwrite drops the other valid
        if (fault_ev_in.data_access_violation) begin
            next_fault_addr = data_fault_addr_in;
            bus_clr[MFS_BIT_ADDR_VALID] = 1'b1;
        end else if (fault_ev_in.precise_data_bus_error) begin
            next_fault_addr = bus_fault_addr_in;
            mp_clr[MFS_BIT_ADDR_VALID] = 1'b1;
        end

        // RULE18 sticky, set wins over clear
        next_memprot_fault_cause = ((memprot_fault_cause & ~mp_clr) | mp_set) & MFS_MEMPROT_MASK;
        next_bus_fault_cause     = ((bus_fault_cause & ~bus_clr) | bus_set) & MFS_BUS_MASK;

        // RULE15 pending while higher priority runs
        if (fault_ev_in.imprecise_data_bus_error) begin
            next_imprecise_pend = 1'b1;
        end else if (bus_fault_taken_in) begin
            next_imprecise_pend = 1'b0;
        end

        // RULE4 stacking still adjusts SP
        // RULE12 stacking still adjusts SP
        next_frame_ctl.adjust_sp = fault_ev_in.memprot_stacking_fault
                                   | fault_ev_in.bus_stacking_fault;
        // RULE5 unstacking keeps return frame
        // RULE13 unstacking keeps return frame
        next_frame_ctl.keep_return_frame = fault_ev_in.memprot_unstacking_fault
                                           | fault_ev_in.bus_unstacking_fault;
        // RULE6 faulting PC is stacked
        // RULE14 faulting PC is stacked
        next_frame_ctl.stacked_pc_faulting = fault_ev_in.data_access_violation
                                             | fault_ev_in.precise_data_bus_error
                                             | fault_ev_in.fetch_access_violation;

        // RULE17 byte lanes of the fault word
        if (sc_rd_in) begin
            next_rdata = 32'h0000_0000;
            if (mp_hit) begin
                next_rdata[7:0] = memprot_fault_cause;
            end
            if (bus_hit) begin
                next_rdata[15:8] = bus_fault_cause;
            end
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        // RULE19 reset clears all flags
        if (sys_rst_in) begin
            memprot_fault_cause <= MFS_CAUSE_RESET;
            bus_fault_cause     <= MFS_CAUSE_RESET;
            fault_addr          <= MFS_ADDR_RESET;
            prefetch_err        <= 1'b0;
            imprecise_pend      <= 1'b0;
            rdata               <= 32'h0000_0000;
            frame_ctl           <= '0;
        end else begin
            memprot_fault_cause <= next_memprot_fault_cause;
            bus_fault_cause     <= next_bus_fault_cause;
            fault_addr          <= next_fault_addr;
            prefetch_err        <= next_prefetch_err;
            imprecise_pend      <= next_imprecise_pend;
            rdata               <= next_rdata;
            frame_ctl           <= next_frame_ctl;
        end
    end

    assign sc_rdata_out            = rdata;
    assign memprot_fault_cause_out = memprot_fault_cause;
    assign bus_fault_cause_out     = bus_fault_cause;
    assign fault_addr_out          = fault_addr;
    assign frame_ctl_out           = frame_ctl;
    assign bus_fault_req_out       = imprecise_pend & ~bus_blocked;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    a_mp_valid_addr: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE1
        fault_ev_in.data_access_violation |=> memprot_fault_cause[MFS_BIT_ADDR_VALID]
            && fault_addr == $past(data_fault_addr_in))
        else $error("memprot valid or address not loaded");

    a_mp_lazy_set: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE3
        fault_ev_in.memprot_lazy_fp_fault |=> memprot_fault_cause[MFS_BIT_LAZY_FP])
        else $error("memprot lazy flag not set");

    a_stack_no_addr: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE4
        (fault_ev_in.memprot_stacking_fault && !fault_ev_in.data_access_violation
         && !fault_ev_in.precise_data_bus_error)
        |=> $stable(fault_addr) && frame_ctl.adjust_sp && memprot_fault_cause[MFS_BIT_STACKING])
        else $error("stacking fault handled wrongly");

    a_unstack_chain: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE13
        fault_ev_in.bus_unstacking_fault
        |=> frame_ctl.keep_return_frame && bus_fault_cause[MFS_BIT_UNSTACKING])
        else $error("bus unstacking fault handled wrongly");

    a_fetch_viol: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE7
        fault_ev_in.fetch_access_violation
        |=> memprot_fault_cause[MFS_BIT_FETCH] && frame_ctl.stacked_pc_faulting)
        else $error("fetch violation not flagged");

    a_bus_valid_set: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE8
        (fault_ev_in.precise_data_bus_error && !fault_ev_in.data_access_violation)
        |=> bus_fault_cause[MFS_BIT_ADDR_VALID] && bus_fault_cause[MFS_BIT_DATA]
            && fault_addr == $past(bus_fault_addr_in))
        else $error("bus valid or address missing");

    a_bus_valid_drop: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE9
        fault_ev_in.data_access_violation |=> !bus_fault_cause[MFS_BIT_ADDR_VALID])
        else $error("bus valid kept after overwrite");

    a_imprecise_pend: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE15
        (fault_ev_in.imprecise_data_bus_error && !bus_fault_taken_in)
        ##1 (cur_prio_in <= bus_prio_in) |-> !bus_fault_req_out && imprecise_pend)
        else $error("imprecise fault not held pending");

    a_ibus_on_issue: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE16
        $rose(bus_fault_cause[MFS_BIT_FETCH]) |-> $past(fault_ev_in.prefetch_issue))
        else $error("instruction bus flag set without issue");

    a_sticky_flags: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE18
        (!sc_wr_in && !fault_ev_in.precise_data_bus_error)
        |=> (memprot_fault_cause & $past(memprot_fault_cause)) == $past(memprot_fault_cause)
            && memprot_fault_cause[6] == 1'b0 && memprot_fault_cause[2] == 1'b0)
        else $error("memprot flag lost without clear");

    a_read_lane: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // RULE17
        (sc_rd_in && sc_size_in == MFS_SIZE_BYTE && sc_addr_in == MFS_FAULT_WORD_ADDR + 32'h1)
        |=> sc_rdata_out == {16'h0000, $past(bus_fault_cause), 8'h00})
        else $error("bus byte read wrong");

    a_reset_clear: assert property (@(posedge mclk_in) // RULE19
        sys_rst_in |=> memprot_fault_cause == 8'h00 && bus_fault_cause == 8'h00)
        else $error("flags not cleared by reset");

endmodule

`default_nettype wire

// ### tb.sv
// Self-checking bench for the fault cause status bytes.
// Assumes mfs_pkg and mfs_fault_status are compiled ahead of it.
`timescale 1ns/10ps
`default_nettype none

module tb;
    import mfs_pkg::*;

    // ---------------------------------------------------------------
    // Signals and bench model
    // ---------------------------------------------------------------
    logic              mclk_in;
    logic              sys_rst_in;
    mfs_fault_ev_type  fault_ev_in;
    logic [31:0]       data_fault_addr_in;
    logic [31:0]       bus_fault_addr_in;
    logic [7:0]        cur_prio_in;
    logic [7:0]        bus_prio_in;
    logic              bus_fault_taken_in;
    logic [31:0]       sc_addr_in;
    logic [1:0]        sc_size_in;
    logic              sc_rd_in;
    logic              sc_wr_in;
    logic [31:0]       sc_wdata_in;
    logic [31:0]       sc_rdata_out;
    logic [7:0]        memprot_fault_cause_out;
    logic [7:0]        bus_fault_cause_out;
    logic [31:0]       fault_addr_out;
    mfs_frame_ctl_type frame_ctl_out;
    logic              bus_fault_req_out;
    integer            errors = 0;
    integer            n_compared = 0;
    integer            seed = 92;
    integer            cycles = 0;
    logic [7:0]        mp;
    logic [7:0]        bs;
    logic [31:0]       addr;
    logic              imp_pend;
    logic              pf_pend;
    logic [31:0]       ta [6] = '{32'hE000_ED28, 32'hE000_ED29, 32'hE000_ED28,
                                  32'hE000_ED28, 32'hE000_ED2A, 32'hE000_ED2C};
    logic [1:0]        ts [6] = '{MFS_SIZE_BYTE, MFS_SIZE_BYTE, MFS_SIZE_HALF,
                                  MFS_SIZE_WORD, MFS_SIZE_HALF, MFS_SIZE_WORD};

    mfs_fault_status DUT (
        .mclk_in                 (mclk_in),
        .sys_rst_in              (sys_rst_in),
        .fault_ev_in             (fault_ev_in),
        .data_fault_addr_in      (data_fault_addr_in),
        .bus_fault_addr_in       (bus_fault_addr_in),
        .cur_prio_in             (cur_prio_in),
        .bus_prio_in             (bus_prio_in),
        .bus_fault_taken_in      (bus_fault_taken_in),
        .sc_addr_in              (sc_addr_in),
        .sc_size_in              (sc_size_in),
        .sc_rd_in                (sc_rd_in),
        .sc_wr_in                (sc_wr_in),
        .sc_wdata_in             (sc_wdata_in),
        .sc_rdata_out            (sc_rdata_out),
        .memprot_fault_cause_out (memprot_fault_cause_out),
        .bus_fault_cause_out     (bus_fault_cause_out),
        .fault_addr_out          (fault_addr_out),
        .frame_ctl_out           (frame_ctl_out),
        .bus_fault_req_out       (bus_fault_req_out)
    );

    // ---------------------------------------------------------------
    // Clock and timeout
    // ---------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("[FAIL] %0t run timed out", $time);
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // Checking and model tasks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_state();
        chk({24'h0, memprot_fault_cause_out}, {24'h0, mp}, "memprot byte");
        chk({24'h0, bus_fault_cause_out}, {24'h0, bs}, "bus byte");
        chk(fault_addr_out, addr, "fault address");
        chk({31'h0, bus_fault_req_out}, {31'h0, imp_pend && (cur_prio_in > bus_prio_in)},
            "pending request");
    endtask

    function automatic logic [1:0] lanes(input logic [31:0] a, input logic [1:0] sz);
        if (a[31:2] != MFS_FAULT_WORD_ADDR[31:2]) return 2'b00;
        if (sz == MFS_SIZE_WORD) return 2'b11;
        if (sz == MFS_SIZE_HALF) return (a[1:0] == 2'h0) ? 2'b11 : 2'b00;
        if (a[1:0] == 2'h0) return 2'b01;
        return (a[1:0] == 2'h1) ? 2'b10 : 2'b00;
    endfunction

    // Expected effect of one event, bit index as in the event struct
    task automatic model(input int k);
        case (k)
            12: mp[0] = 1'b1;
            11: begin
                mp = mp | 8'h82;
                bs[7] = 1'b0;
                addr = data_fault_addr_in;
            end
            10: mp[4] = 1'b1;
            9: mp[3] = 1'b1;
            8: mp[5] = 1'b1;
            7: begin
                bs = bs | 8'h82;
                mp[7] = 1'b0;
                addr = bus_fault_addr_in;
            end
            6: begin
                bs[2] = 1'b1;
                imp_pend = 1'b1;
            end
            5: bs[4] = 1'b1;
            4: bs[3] = 1'b1;
            3: bs[5] = 1'b1;
            2: pf_pend = 1'b1;
            1: begin
                bs[0] = bs[0] | pf_pend;
                pf_pend = 1'b0;
            end
            default: pf_pend = 1'b0;
        endcase
    endtask

    task automatic pulse(input int k);
        logic [12:0] v;
        logic [2:0]  fexp;
        v = 13'h0;
        v[k] = 1'b1;
        fexp = {k == 10 || k == 5, k == 9 || k == 4, k == 12 || k == 11 || k == 7};
        @(negedge mclk_in);
        fault_ev_in <= mfs_fault_ev_type'(v);
        data_fault_addr_in <= $random(seed);
        bus_fault_addr_in <= $random(seed);
        {cur_prio_in, bus_prio_in} <= 16'($random(seed));
        @(negedge mclk_in);
        fault_ev_in <= '0;
        model(k);
        check_state();
        if (k > 3 && k != 6 && k != 8) chk({29'h0, frame_ctl_out}, {29'h0, fexp}, "frame");
    endtask

    task automatic set_prio(input logic [7:0] c, input logic [7:0] b, input logic take);
        @(negedge mclk_in);
        cur_prio_in <= c;
        bus_prio_in <= b;
        bus_fault_taken_in <= take;
        @(negedge mclk_in);
        bus_fault_taken_in <= 1'b0;
        if (take) imp_pend = 1'b0;
        check_state();
    endtask

    task automatic sc_access(input logic wr, input int i, input logic [31:0] d);
        logic [1:0]  ln;
        logic [31:0] exp;
        ln = lanes(ta[i], ts[i]);
        exp = {16'h0, ln[1] ? bs : 8'h00, ln[0] ? mp : 8'h00};
        @(negedge mclk_in);
        sc_addr_in <= ta[i];
        sc_size_in <= ts[i];
        sc_wdata_in <= d;
        sc_rd_in <= !wr;
        sc_wr_in <= wr;
        @(negedge mclk_in);
        sc_rd_in <= 1'b0;
        sc_wr_in <= 1'b0;
        if (wr) begin
            if (ln[0]) mp = mp & ~d[7:0];
            if (ln[1]) bs = bs & ~d[15:8];
            check_state();
        end else begin
            chk(sc_rdata_out, exp, "read data");
        end
    endtask

    task automatic do_reset();
        @(negedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (20) @(negedge mclk_in);
        sys_rst_in <= 1'b0;
        {mp, bs, addr, imp_pend, pf_pend} = '0;
        check_state();
        chk({29'h0, frame_ctl_out}, 32'h0, "frame after reset");
        $display("reset test done");
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] r;
        {fault_ev_in, data_fault_addr_in, bus_fault_addr_in} = '0;
        {cur_prio_in, bus_prio_in, bus_fault_taken_in} = '0;
        {sc_addr_in, sc_size_in, sc_rd_in, sc_wr_in, sc_wdata_in} = '0;
        sys_rst_in = 1'b1;
        do_reset();
        pulse(11);
        pulse(7);
        sc_access(1'b1, 1, 32'h0000_8000);
        pulse(7);
        pulse(11);
        for (int k = 3; k < 13; k++) pulse(k);
        sc_access(1'b1, 0, 32'h0000_0080);
        for (int i = 0; i < 6; i++) sc_access(1'b0, i, 32'h0);
        sc_access(1'b1, 0, 32'h0000_00FF);
        sc_access(1'b1, 3, 32'hFFFF_FFFF);
        $display("cause bits test done");
        pulse(2);
        pulse(0);
        pulse(1);
        pulse(2);
        pulse(1);
        $display("prefetch test done");
        pulse(6);
        set_prio(8'h10, 8'h20, 1'b0);
        set_prio(8'h20, 8'h20, 1'b0);
        set_prio(8'h30, 8'h20, 1'b0);
        set_prio(8'h30, 8'h20, 1'b1);
        $display("imprecise test done");
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            if (r[3:2] != 2'b11) pulse(int'(r[7:4]) % 13);
            else if (r[1]) sc_access(r[0], int'(r[10:8]) % 6, $random(seed));
            else set_prio(r[23:16], r[31:24], 1'b1);
        end
        $display("random test done");
        do_reset();
        report_and_stop();
    end
endmodule

`default_nettype wire
